// ==== pkg/rdr_pkg.sv ====
// Constants and types for the RTD range and diagnostic record block
package rdr_pkg;
    // Clock and microsecond ticker timing
    localparam int          CLK_NS      = 100;
    localparam int          US_NS       = 1000;
    localparam int          US_CYC      = US_NS / CLK_NS;
    // Access routes on the read port
    localparam logic [1:0]  ROUTE_DS    = 2'h0;
    localparam logic [1:0]  ROUTE_CAN   = 2'h1;
    localparam logic [1:0]  ROUTE_ECAT  = 2'h2;
    // Record set numbers, object indices and subindices
    localparam logic [15:0] DS_SHORT    = 16'h0000;
    localparam logic [15:0] DS_FULL     = 16'h0001;
    localparam logic [15:0] IX_SHORT    = 16'h2F00;
    localparam logic [15:0] IX_FULL     = 16'h2F01;
    localparam logic [15:0] IX_ECAT     = 16'h5005;
    localparam logic [7:0]  SX_FIRST    = 8'h02;
    localparam logic [7:0]  SX_RSV_LAST = 8'h11;
    localparam logic [7:0]  SX_STAMP    = 8'h13;
    // Record layout in bytes
    localparam logic [4:0]  SHORT_LEN   = 5'h04;
    localparam logic [4:0]  REC_LEN     = 5'h14;
    localparam logic [4:0]  STAMP_POS   = 5'h10;
    // Fixed descriptor and reset values
    localparam logic [7:0]  MOD_CLASS   = 8'h15;
    localparam logic [7:0]  CHAN_KIND   = 8'h71;
    localparam logic [7:0]  FLAG_COUNT  = 8'h08;
    localparam logic [7:0]  CHAN_COUNT  = 8'h04;
    localparam logic [7:0]  ERR_RST     = 8'h00;
    // Summary byte bit positions
    localparam int          A_MODFAIL   = 0;
    localparam int          A_INT       = 1;
    localparam int          A_EXT       = 2;
    localparam int          A_CHAN      = 3;
    localparam int          A_AUX       = 4;
    localparam int          A_PARAM     = 7;
    localparam int          D_COMM      = 4;
    // Channel fault byte bit positions
    localparam int          C_PARAM     = 0;
    localparam int          C_WIRE      = 4;
    localparam int          C_UNDER     = 6;
    localparam int          C_OVER      = 7;
    // Function codes: off, and code groups (code bits 7:3)
    localparam logic [7:0]  FN_OFF      = 8'hFF;
    localparam logic [4:0]  FN_LIN_2W   = 5'h12;
    localparam logic [4:0]  FN_LIN_3W   = 5'h13;
    localparam logic [4:0]  FN_LIN_4W   = 5'h14;
    localparam logic [4:0]  FN_STD_2W   = 5'h1A;
    localparam logic [4:0]  FN_STD_3W   = 5'h1B;
    localparam logic [4:0]  FN_STD_4W   = 5'h1C;
    localparam logic [2:0]  FN_SUB_MAX  = 3'h2;
    // Digital spans and limits
    localparam logic [15:0] SPAN_LO     = 16'h1770;
    localparam logic [15:0] SPAN_HI     = 16'h7530;
    localparam logic [15:0] SPAN_STD    = 16'h6C00;
    localparam logic [15:0] OVR_LIM     = 16'h7EFF;
    localparam int          RAW_FS_BITS = 14;
    localparam logic [15:0] RAW_OVR     = 16'h4B43;
    // Range kind decoded from a function code
    typedef enum logic [1:0] {
        K_OFF = 2'b00,
        K_LIN = 2'b01,
        K_STD = 2'b10,
        K_BAD = 2'b11
    } rdr_kind_t;
endpackage

// ==== hdl/rdr_diag_record.sv ====
// Diagnostic record, range decode and scaling for a four-channel RTD input
//
// Functional notes
// - Record set 01h full, 00h first four bytes
// - Index 2F01h full record, 2F00h first four
// - EtherCAT index 5005h, subindex 02h to 11h and 13h
// - No diagnostic interrupt; record polled only
// - Error lights channel indicator and is recorded
// - Report parameter, overrange and underrange errors
// - Summary bits: failure, internal, external, channel
// - Summary bit 4 aux supply; 6:5 reserved
// - Summary bit 7 on bad parameters
// - Fixed descriptor bytes 15h, 71h, 08h, 04h
// - Four channel bytes, then four zero bytes
// - Codes 9xh/A0h scale to 6000 or 30000
// - Codes Dxh/E0h scale to 27648, limit 32511
// - Function code FFh switches channel off
// - Channel bits: param, wire, under, over
// - Microsecond counter stamped on each diagnostic
`timescale 1ns/1ns
module rdr_diag_record
    import rdr_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        RD_REQ,
    input  wire logic [1:0]  RD_ROUTE,
    input  wire logic [15:0] RD_SEL,
    input  wire logic [7:0]  RD_SUB,
    input  wire logic [4:0]  RD_BYTE,
    output logic             RD_ACK,
    output logic [7:0]       RD_DATA,
    output logic             RD_ERR,
    input  wire logic        FN_WE,
    input  wire logic [1:0]  FN_CH,
    input  wire logic [7:0]  FN_CODE,
    input  wire logic        MEAS_STB,
    input  wire logic [1:0]  MEAS_CH,
    input  wire logic [15:0] MEAS_RAW,
    input  wire logic        AUX_MISSING,
    input  wire logic        MOD_FAIL,
    input  wire logic        COMM_FAULT,
    input  wire logic [3:0]  WIRE_BREAK,
    output logic             VAL_STB,
    output logic [1:0]       VAL_CH,
    output logic [15:0]      VAL_DATA,
    output logic [3:0]       CH_LED
);

    // Whole state of the block in one register: pin synchronisers, live
    // fault bytes, ticker, stamp and the registered read and value outputs.
    // One packed struct keeps reset and next-state handling uniform.
    typedef struct packed {
        logic [2:0]      aux_s;
        logic [2:0]      mf_s;
        logic [2:0]      cf_s;
        logic [2:0][3:0] wb_s;
        logic            aux;
        logic            mf;
        logic            cf;
        logic [3:0]      wb;
        logic [3:0][7:0] fn;
        logic [3:0][7:0] chf;
        logic [7:0]      err_a;
        logic [7:0]      err_d;
        logic [3:0]      pre;
        logic [31:0]     us;
        logic [31:0]     stamp;
        logic            ack;
        logic            err;
        logic [7:0]      rdata;
        logic            vstb;
        logic [1:0]      vch;
        logic [15:0]     val;
        logic [3:0]      led;
    } rdr_state_t;

    rdr_state_t state_reg;
    rdr_state_t state_next;

    // Range kind of a function code; shared by flag and conversion paths.
    // Codes outside the wiring groups, or with a sub-code above two, are
    // refused as parameter errors rather than converted on a guess.
    function automatic rdr_kind_t fn_kind(input logic [7:0] code);
        rdr_kind_t k;
        k = K_BAD;
        if (code == FN_OFF) begin
            k = K_OFF;
        end else if (code[2:0] <= FN_SUB_MAX) begin
            case (code[7:3])
                FN_LIN_2W, FN_LIN_3W, FN_LIN_4W: k = K_LIN;
                FN_STD_2W, FN_STD_3W, FN_STD_4W: k = K_STD;
                default:                         k = K_BAD;
            endcase
        end
        return k;
    endfunction

    logic [REC_LEN*8-1:0] rec;
    logic [7:0]           channel_group_fault_map;
    logic [7:0]           new_a;
    logic [7:0]           new_d;
    logic [7:0]           f;
    logic [3:0]           any_ext;
    logic [15:0]          raw_c;
    logic [15:0]          span;
    logic [31:0]          prod;
    logic [15:0]          scaled;
    rdr_kind_t            k;
    logic                 full;
    logic                 short_rec;
    logic [4:0]           pos;
    logic                 in_map;
    logic [4:0]           limit;

    // Next-state logic
    // Defaults come first so that no path infers a latch; every field keeps
    // its value unless a branch below updates it.
    always_comb begin
        state_next = state_reg;
        rec        = '0;
        channel_group_fault_map      = '0;
        new_a      = '0;
        new_d      = '0;
        f          = '0;
        any_ext    = '0;
        raw_c      = '0;
        span       = '0;
        prod       = '0;
        scaled     = '0;
        k          = K_OFF;
        full       = 1'b0;
        short_rec  = 1'b0;
        pos        = '0;
        in_map     = 1'b0;
        limit      = '0;

        // Pin synchronisers: a level is taken once stages two and three agree
        // Three stages guard against metastability, and the agreement test
        // filters a single-cycle glitch at the cost of four edges.
        state_next.aux_s = {state_reg.aux_s[1:0], AUX_MISSING};
        state_next.mf_s  = {state_reg.mf_s[1:0], MOD_FAIL};
        state_next.cf_s  = {state_reg.cf_s[1:0], COMM_FAULT};
        state_next.wb_s  = {state_reg.wb_s[1:0], WIRE_BREAK};
        if (state_reg.aux_s[1] == state_reg.aux_s[2]) begin
            state_next.aux = state_reg.aux_s[2];
        end
        if (state_reg.mf_s[1] == state_reg.mf_s[2]) begin
            state_next.mf = state_reg.mf_s[2];
        end
        if (state_reg.cf_s[1] == state_reg.cf_s[2]) begin
            state_next.cf = state_reg.cf_s[2];
        end
        for (int i = 0; i < 4; i++) begin
            if (state_reg.wb_s[1][i] == state_reg.wb_s[2][i]) begin
                state_next.wb[i] = state_reg.wb_s[2][i];
            end
        end

        // Free-running microsecond ticker, wraps through zero
        // The wrap raises no flag, so a reader comparing two stamps must
        // allow for it; the prescaler counts clock cycles per microsecond.
        if (state_reg.pre == 4'(US_CYC - 1)) begin
            state_next.pre = '0;
            state_next.us  = state_reg.us + 32'h00000001;
        end else begin
            state_next.pre = state_reg.pre + 4'h1;
        end

        // Function code parameter write
        // The new code is seen in the same cycle by the fault and value paths.
        if (FN_WE) begin
            state_next.fn[FN_CH] = FN_CODE;
        end

        // Channel fault bytes follow the current code, pins and last sample
        // Flags are live, not sticky: with no clear path a latched flag could
        // never be retired, so an off channel simply reads all zero.
        for (int i = 0; i < 4; i++) begin
            f = state_reg.chf[i];
            case (fn_kind(state_next.fn[i]))
                K_OFF: f = ERR_RST;
                K_BAD: begin
                    f = ERR_RST;
                    f[C_PARAM] = 1'b1;
                end
                default: begin
                    f[C_PARAM] = 1'b0;
                    f[C_WIRE]  = state_next.wb[i];
                    if (MEAS_STB && (MEAS_CH == 2'(i))) begin
                        f[C_UNDER] = MEAS_RAW[15];
                        f[C_OVER]  = !MEAS_RAW[15] && (MEAS_RAW > RAW_OVR);
                    end
                end
            endcase
            state_next.chf[i] = f;
            channel_group_fault_map[i]          = (f != ERR_RST);
            any_ext[i]        = f[C_WIRE] | f[C_UNDER] | f[C_OVER];
            state_next.led[i] = (f != ERR_RST);
        end

        // Conversion; a bad or off channel produces no value
        // The raw sample is clamped before scaling, so the product always
        // fits 32 bits and the overrange value is reached, not wrapped.
        k     = fn_kind(state_next.fn[MEAS_CH]);
        raw_c = MEAS_RAW[15] ? 16'h0000 : ((MEAS_RAW > RAW_OVR) ? RAW_OVR : MEAS_RAW);
        span  = (k == K_STD) ? SPAN_STD : (state_next.fn[MEAS_CH][1] ? SPAN_HI : SPAN_LO);
        prod  = raw_c * span;
        scaled = prod[RAW_FS_BITS+15:RAW_FS_BITS];
        if ((k == K_STD) && (scaled > OVR_LIM)) begin
            scaled = OVR_LIM;
        end
        state_next.vstb = MEAS_STB && ((k == K_LIN) || (k == K_STD));
        if (state_next.vstb) begin
            state_next.vch = MEAS_CH;
            state_next.val = scaled;
        end

        // Summary bytes; bits 6:5 stay zero
        new_d[D_COMM]    = state_next.cf;
        new_a[A_MODFAIL] = state_next.mf;
        new_a[A_INT]     = (new_d != ERR_RST);
        new_a[A_EXT]     = state_next.aux | (|any_ext);
        new_a[A_CHAN]    = (channel_group_fault_map != ERR_RST);
        new_a[A_AUX]     = state_next.aux;
        for (int i = 0; i < 4; i++) begin
            new_a[A_PARAM] = new_a[A_PARAM] | state_next.chf[i][C_PARAM];
        end
        state_next.err_a = new_a;
        state_next.err_d = new_d;

        // A newly raised fault stamps the ticker value
        // Only rising bits count, so a standing fault does not move the stamp.
        if (((new_a & ~state_reg.err_a) != ERR_RST) ||
            ((new_d & ~state_reg.err_d) != ERR_RST) ||
            ((state_next.chf & ~state_reg.chf) != '0)) begin
            state_next.stamp = state_reg.us;
        end

        // Record image, byte 0 lowest; ticker sent most significant first
        rec = {state_reg.stamp[7:0], state_reg.stamp[15:8],
               state_reg.stamp[23:16], state_reg.stamp[31:24],
               32'h00000000, state_reg.chf, channel_group_fault_map, CHAN_COUNT, FLAG_COUNT,
               CHAN_KIND, state_reg.err_d, ERR_RST, MOD_CLASS,
               state_reg.err_a};

        // Read decode per route; no interrupt, the head module polls
        // A refused access still answers, with the error bit and zero data,
        // so the poller never waits on a missing acknowledge.
        case (RD_ROUTE)
            ROUTE_DS: begin
                full      = (RD_SEL == DS_FULL);
                short_rec = (RD_SEL == DS_SHORT);
                pos       = RD_BYTE;
            end
            ROUTE_CAN: begin
                full      = (RD_SEL == IX_FULL);
                short_rec = (RD_SEL == IX_SHORT);
                pos       = RD_BYTE;
            end
            ROUTE_ECAT: begin
                in_map = (RD_SEL == IX_ECAT);
                if (in_map && (RD_SUB >= SX_FIRST) && (RD_SUB <= SX_RSV_LAST)) begin
                    full = 1'b1;
                    pos  = 5'(RD_SUB - SX_FIRST);
                end else if (in_map && (RD_SUB == SX_STAMP)) begin
                    full = 1'b1;
                    pos  = STAMP_POS + {3'h0, RD_BYTE[1:0]};
                end
            end
            default: full = 1'b0;
        endcase
        limit = full ? REC_LEN : (short_rec ? SHORT_LEN : 5'h00);
        state_next.ack = RD_REQ;
        if (RD_REQ) begin
            state_next.err   = (pos >= limit);
            state_next.rdata = (pos >= limit) ? ERR_RST : rec[pos*8 +: 8];
        end
    end

    // State register; channels power up switched off
    // Starting off avoids false range faults before the head module configures.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg       <= '0;
            state_reg.fn    <= {4{FN_OFF}};
            state_reg.err_a <= ERR_RST;
            state_reg.err_d <= ERR_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    // No logic sits after the flops, so the pins carry no combinational glitches.
    assign RD_ACK   = state_reg.ack;
    assign RD_DATA  = state_reg.rdata;
    assign RD_ERR   = state_reg.err;
    assign VAL_STB  = state_reg.vstb;
    assign VAL_CH   = state_reg.vch;
    assign VAL_DATA = state_reg.val;
    assign CH_LED   = state_reg.led;

endmodule

// ==== dv/rdr_chk.sv ====
// Port assertions for the diagnostic record block
`timescale 1ns/1ns
module rdr_chk
    import rdr_pkg::*;
(
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        RD_REQ,
    input wire logic [1:0]  RD_ROUTE,
    input wire logic [15:0] RD_SEL,
    input wire logic [4:0]  RD_BYTE,
    input wire logic        RD_ACK,
    input wire logic [7:0]  RD_DATA,
    input wire logic        RD_ERR,
    input wire logic        FN_WE,
    input wire logic [1:0]  FN_CH,
    input wire logic [7:0]  FN_CODE,
    input wire logic        MEAS_STB,
    input wire logic [1:0]  MEAS_CH,
    input wire logic        VAL_STB,
    input wire logic [3:0]  CH_LED
);
    // All checks live in the one clock domain
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    chk_ack_follows: assert property (RD_REQ |=> RD_ACK)
        else $error("read request not answered");
    chk_ack_cause: assert property (RD_ACK |-> $past(RD_REQ))
        else $error("answer without request");
    chk_err_data: assert property (RD_ACK && RD_ERR |-> RD_DATA == 8'h00)
        else $error("refused read carries data");
    chk_short_set: assert property (RD_REQ && RD_ROUTE == ROUTE_DS && RD_SEL == DS_SHORT
        && RD_BYTE >= SHORT_LEN |=> RD_ERR) else $error("short set read past four bytes");
    chk_can_short: assert property (RD_REQ && RD_ROUTE == ROUTE_CAN && RD_SEL == IX_SHORT
        && RD_BYTE >= SHORT_LEN |=> RD_ERR) else $error("short index read past four bytes");
    chk_route_none: assert property (RD_REQ && RD_ROUTE == 2'h3 |=> RD_ERR)
        else $error("unmapped route accepted");
    chk_full_desc: assert property (RD_REQ && RD_ROUTE == ROUTE_DS && RD_SEL == DS_FULL
        && RD_BYTE == 5'h04 |=> !RD_ERR && RD_DATA == 8'h71) else $error("channel kind wrong");
    chk_val_cause: assert property (VAL_STB |-> $past(MEAS_STB))
        else $error("value without sample");
    chk_off_quiet: assert property (MEAS_STB && FN_WE && FN_CH == MEAS_CH
        && FN_CODE == 8'hFF |=> !VAL_STB) else $error("switched off channel converted");
    chk_bad_led: assert property (FN_WE && FN_CODE == 8'h33 |=> CH_LED[$past(FN_CH)])
        else $error("bad code does not light indicator");
    // Main scenarios
    cover property (RD_ACK && !RD_ERR);
    cover property (RD_ACK && RD_ERR);
    cover property (VAL_STB);
endmodule
bind rdr_diag_record rdr_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .RD_REQ(RD_REQ),
    .RD_ROUTE(RD_ROUTE), .RD_SEL(RD_SEL), .RD_BYTE(RD_BYTE), .RD_ACK(RD_ACK),
    .RD_DATA(RD_DATA), .RD_ERR(RD_ERR), .FN_WE(FN_WE), .FN_CH(FN_CH), .FN_CODE(FN_CODE),
    .MEAS_STB(MEAS_STB), .MEAS_CH(MEAS_CH), .VAL_STB(VAL_STB), .CH_LED(CH_LED));

// ==== dv/rdr_head_model.sv ====
// Head module model that polls the diagnostic record
`timescale 1ns/1ns
module rdr_head_model (
    input  wire logic        CLK,
    input  wire logic        RD_ACK,
    input  wire logic [7:0]  RD_DATA,
    input  wire logic        RD_ERR,
    output logic             RD_REQ,
    output logic [1:0]       RD_ROUTE,
    output logic [15:0]      RD_SEL,
    output logic [7:0]       RD_SUB,
    output logic [4:0]       RD_BYTE
);
    initial begin
        {RD_REQ, RD_ROUTE, RD_SEL, RD_SUB, RD_BYTE} = '0;
    end
    // One polled read; with no interrupt line polling is the only path
    task automatic poll(input logic [1:0] r, input logic [15:0] s, input logic [7:0] x,
        input logic [4:0] b, output logic [7:0] d, output logic e, output logic a);
        {RD_REQ, RD_ROUTE, RD_SEL, RD_SUB, RD_BYTE} = {1'b1, r, s, x, b};
        @(posedge CLK);
        #1;
        // Answer is registered at the taking edge and is settled here
        {a, d, e} = {RD_ACK, RD_DATA, RD_ERR};
        // Released lines show the inverse so a stale address cannot pass
        {RD_REQ, RD_ROUTE, RD_SEL, RD_SUB, RD_BYTE} = {1'b0, ~r, ~s, ~x, ~b};
        @(posedge CLK);
        #1;
    endtask
endmodule

// ==== dv/rdr_diag_record_test.sv ====
// Self-checking bench for the diagnostic record block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module rdr_diag_record_test
    import rdr_pkg::*;
;
    logic        CLK, ARST_N, FN_WE, MEAS_STB, AUX_MISSING, MOD_FAIL, COMM_FAULT;
    logic        RD_REQ, RD_ACK, RD_ERR, VAL_STB;
    logic [1:0]  FN_CH, MEAS_CH, RD_ROUTE, VAL_CH;
    logic [3:0]  WIRE_BREAK, CH_LED;
    logic [4:0]  RD_BYTE;
    logic [7:0]  FN_CODE, RD_DATA, RD_SUB, d;
    logic [15:0] MEAS_RAW, RD_SEL, VAL_DATA;
    logic [31:0] st;
    logic        e, a;
    int          fails, checks, cyc, t0, fn[4], und[4], ovr[4];
    rdr_diag_record u_dut (.CLK(CLK), .ARST_N(ARST_N), .RD_REQ(RD_REQ), .RD_ROUTE(RD_ROUTE),
        .RD_SEL(RD_SEL), .RD_SUB(RD_SUB), .RD_BYTE(RD_BYTE), .RD_ACK(RD_ACK), .RD_DATA(RD_DATA),
        .RD_ERR(RD_ERR), .FN_WE(FN_WE), .FN_CH(FN_CH), .FN_CODE(FN_CODE), .MEAS_STB(MEAS_STB),
        .MEAS_CH(MEAS_CH), .MEAS_RAW(MEAS_RAW), .AUX_MISSING(AUX_MISSING), .MOD_FAIL(MOD_FAIL),
        .COMM_FAULT(COMM_FAULT), .WIRE_BREAK(WIRE_BREAK), .VAL_STB(VAL_STB), .VAL_CH(VAL_CH),
        .VAL_DATA(VAL_DATA), .CH_LED(CH_LED));
    rdr_head_model u_host (.CLK(CLK), .RD_ACK(RD_ACK), .RD_DATA(RD_DATA), .RD_ERR(RD_ERR),
        .RD_REQ(RD_REQ), .RD_ROUTE(RD_ROUTE), .RD_SEL(RD_SEL), .RD_SUB(RD_SUB), .RD_BYTE(RD_BYTE));
    // Range codes by number; 18 stands for the off code
    function automatic int good(int n);
        int base[6] = '{'h90, 'h98, 'hA0, 'hD0, 'hD8, 'hE0};
        return n > 17 ? 'hFF : base[n / 3] + n % 3;
    endfunction
    // Digital span of a code, 0 when the code converts nothing
    function automatic int span(int c);
        for (int n = 0; n < 18; n++)
            if (good(n) == c) return n < 9 ? ((c & 2) ? 30000 : 6000) : 27648;
        return 0;
    endfunction
    function automatic logic [7:0] chb(int i);
        if (fn[i] == 'hFF) return 8'h00;
        if (span(fn[i]) == 0) return 8'h01;
        return {ovr[i][0], und[i][0], 1'b0, WIRE_BREAK[i], 4'h0};
    endfunction
    // Summary byte; bits 6:5 stay clear
    function automatic logic [7:0] summ();
        logic [3:0] m;
        logic       x, p;
        {x, p} = {AUX_MISSING, 1'b0};
        for (int i = 0; i < 4; i++) begin
            m[i] = |chb(i);
            x |= |(chb(i) & 8'hD0);
            p |= |(chb(i) & 8'h01);
        end
        return {p, 2'b00, AUX_MISSING, |m, x, COMM_FAULT, MOD_FAIL};
    endfunction
    // Record byte k; -1 leaves the stamp bytes to their own check
    function automatic int rec(int k);
        logic [7:0] t[16];
        t = '{summ(), 8'h15, 8'h00, {3'h0, COMM_FAULT, 4'h0}, 8'h71, 8'h08, 8'h04,
              {4'h0, |chb(3), |chb(2), |chb(1), |chb(0)}, chb(0), chb(1), chb(2), chb(3),
              8'h00, 8'h00, 8'h00, 8'h00};
        return k < 16 ? int'(t[k]) : -1;
    endfunction
    // Record position of an access, -2 when refused
    function automatic int idx(int r, int s, int x, int b);
        if (r == 0 && s < 2 || r == 1 && (s == 'h2F00 || s == 'h2F01))
            return b < ((s & 1) ? 20 : 4) ? b : -2;
        if (r == 2 && s == 'h5005)
            return (x >= 2 && x <= 'h11) ? x - 2 : (x == 'h13) ? 16 + b % 4 : -2;
        return -2;
    endfunction
    // Every route, selector and byte, a random selector among them
    task automatic sweep();
        int sels[6] = '{0, 1, 'h2F00, 'h2F01, 'h5005, 0};
        int k, v;
        sels[5] = $urandom_range(0, 'hFFFF);
        for (int r = 0; r < 4; r++)
            for (int s = 0; s < 6; s++)
                for (int b = 0; b < 22; b++) begin
                    u_host.poll(r[1:0], sels[s][15:0], b[7:0], b[4:0], d, e, a);
                    k = idx(r, sels[s], b, b);
                    v = k < 0 ? 0 : rec(k);
                    `CHK("ack", 1'b1, a)
                    `CHK("err", k == -2, e)
                    if (v >= 0) `CHK("data", v[7:0], d)
                end
        v = rec(7);
        `CHK("led", v[3:0], CH_LED)
    endtask
    // One sample, with an optional code write in the same cycle
    task automatic step(int ch, int we, int code, int raw);
        int sp, c, v;
        {FN_WE, FN_CH, FN_CODE} = {we[0], ch[1:0], code[7:0]};
        {MEAS_STB, MEAS_CH, MEAS_RAW} = {1'b1, ch[1:0], raw[15:0]};
        if (we) fn[ch] = code;
        sp = span(fn[ch]);
        c = raw < 0 ? 0 : raw > 19267 ? 19267 : raw;
        v = c * sp >> 14;
        if (sp == 27648 && v > 32511) v = 32511;
        // Off and refused channels keep no range flags
        und[ch] = (sp != 0 && raw < 0) ? 1 : 0;
        ovr[ch] = (sp != 0 && raw > 19267) ? 1 : 0;
        @(posedge CLK);
        #1;
        `CHK("vstb", sp != 0, VAL_STB)
        if (sp != 0) `CHK("val", v[15:0], VAL_DATA)
        if (sp != 0) `CHK("vch", ch[1:0], VAL_CH)
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    // Hang guard, far beyond the few thousand cycles the run needs
    initial begin
        #2000000;
        fails++;
        complete_run();
    end
    always @(posedge CLK) cyc <= ARST_N ? cyc + 1 : 0;
    initial begin
        {ARST_N, FN_WE, MEAS_STB, AUX_MISSING, MOD_FAIL, COMM_FAULT} = '0;
        {FN_CH, FN_CODE, MEAS_CH, MEAS_RAW, WIRE_BREAK} = '0;
        fn = '{'hFF, 'hFF, 'hFF, 'hFF};
        und = '{0, 0, 0, 0};
        ovr = '{0, 0, 0, 0};
        t0 = $urandom(32'h337CDD9B);
        repeat (10) @(posedge CLK);
        #1 ARST_N = 1'b1;
        sweep();
        // Unknown code on channel 2 stamps the ticker
        t0 = cyc;
        step(2, 1, 'h33, 0);
        {FN_WE, MEAS_STB} = 2'b00;
        for (int b = 16; b < 20; b++) begin
            u_host.poll(2'h0, 16'h0001, 8'h00, b[4:0], d, e, a);
            st = {st[23:0], d};
        end
        `CHK("stamp", 1'b1, st + 1 >= t0 / 10 && st <= t0 / 10 + 1)
        for (int n = 0; n < 300; n++)
            step(good($urandom_range(0, 2)) % 4 == 2 ? 3 : $urandom_range(0, 1),
                 $urandom_range(0, 1), good($urandom_range(0, 18)),
                 int'($urandom_range(0, 'h5800)) - 'h800);
        // Clamp boundary, then known over, under and normal samples
        step(3, 1, 'hD0, 19267);
        step(0, 1, 'hD0, 'h5000);
        step(1, 1, 'h91, -'h1000);
        step(3, 1, 'hE2, 'h1000);
        {FN_WE, MEAS_STB} = 2'b00;
        {AUX_MISSING, MOD_FAIL, COMM_FAULT, WIRE_BREAK} = 7'($urandom_range(0, 'h7F));
        repeat (6) @(posedge CLK);
        #1;
        sweep();
        complete_run();
    end
endmodule
